/* logic/rflm_pkg.sv */
// Package for the reference and feedback limit monitor
package rflm_pkg;
    // Fixed point: value x 1000, signed 32-bit covers +-999,999.999
    localparam int VAL_W = 32;
    localparam logic signed [31:0] LIMIT_MAX = 32'sh3B9A_C9FF;
    localparam logic signed [31:0] LIMIT_MIN = -32'sh3B9A_C9FF;

    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_REF_LOW = 12'h004;
    localparam logic [11:0] OFF_REF_HIGH = 12'h008;
    localparam logic [11:0] OFF_FB_FLOOR = 12'h00C;
    localparam logic [11:0] OFF_FB_CEIL = 12'h010;
    localparam logic [11:0] OFF_LIVE = 12'h014;
    localparam logic [11:0] OFF_IRQ_STAT = 12'h018;
    localparam logic [11:0] OFF_IRQ_MASK = 12'h01C;
    localparam logic [11:0] OFF_ROUTE = 12'h020;
    localparam logic [11:0] OFF_UNIT = 12'h024;

    // Control fields
    localparam int CTRL_CLOSED_LOOP = 0;
    localparam int CTRL_W = 1;

    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] ROUTE_RST = 32'h0000_0000;
    localparam logic [31:0] UNIT_RST = 32'h0000_0000;
    localparam logic [3:0] MASK_RST = 4'h0;

    // Warning bit positions
    localparam int W_REF_LOW = 0;
    localparam int W_REF_HIGH = 1;
    localparam int W_FEEDBACK_FLOOR_LIMIT = 2;
    localparam int W_FEEDBACK_CEILING_LIMIT = 3;
    localparam int NWARN = 4;

    // Display flash: 250 ms half period
    localparam int FLASH_MS = 250;
    localparam int CLK_MHZ = 100;
    localparam int FLASH_CYC = FLASH_MS * CLK_MHZ * 1000;

    typedef struct packed {
        logic signed [31:0] ref_low;
        logic signed [31:0] ref_high;
        logic signed [31:0] fb_floor;
        logic signed [31:0] fb_ceil;
    } rflm_limits_s;

    typedef struct packed {
        logic running;
        logic at_reference;
        logic remote_sel;
    } rflm_drive_s;

    typedef enum logic [1:0] {
        ST_SUPPRESS = 2'b00,
        ST_ARMED = 2'b01
    } rflm_state_e;
endpackage

/* logic/rflm_compare.sv */
// Strict threshold comparator pair
module rflm_compare (
    input wire logic signed [31:0] value, // Compared quantity
    input wire logic signed [31:0] low_lim, // Low threshold
    input wire logic signed [31:0] high_lim, // High threshold
    input wire logic enable, // Comparison allowed
    output logic below, // Value under low threshold
    output logic above // Value over high threshold
);
    always_comb begin
        below = enable && (value < low_lim);
        above = enable && (value > high_lim);
    end
endmodule

/* logic/rflm_flash.sv */
// Display blink generator
module rflm_flash #(
    parameter int HALF_CYC = rflm_pkg::FLASH_CYC
) (
    input wire logic pclk, // Clock
    input wire logic presetn, // Async reset, active low
    output logic blink // Blink phase
);
    logic [31:0] cnt_reg;
    logic blink_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 32'h0000_0000;
            blink_reg <= 1'b0;
        end else if (cnt_reg >= 32'(HALF_CYC - 1)) begin
            cnt_reg <= 32'h0000_0000;
            blink_reg <= ~blink_reg;
        end else begin
            cnt_reg <= cnt_reg + 32'h0000_0001;
        end
    end

    assign blink = blink_reg;
endmodule

/* logic/rflm_top.sv */
// Reference and feedback limit monitor with APB registers
// Notes on behaviour
// - Remote reference below low reference limit flashes low-reference warning.
// - Resulting reference above high reference limit flashes high-reference warning.
// - Feedback below floor limit flashes low-feedback warning.
// - Feedback above ceiling limit flashes high-feedback warning.
// - Warnings inactive while ramping or stopped; enabled once at reference.
// - Reference warnings evaluated only with remote reference selected.
// - Each warning routable to signal outputs and relays when programmed.
// - High reference limit spans low limit to 999,999.999, default maximum.
// - Feedback ceiling spans floor limit to 999,999.999, never below floor.
// - Reference limits in hertz open loop, process unit closed loop.
// - Closed loop feedback and its limits use the process unit.
module rflm_top #(
    parameter int FLASH_HALF = rflm_pkg::FLASH_CYC
) (
    input wire logic pclk, // Clock, 100 MHz
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic signed [31:0] ref_value, // Active reference, x1000
    input wire logic signed [31:0] fb_value, // Feedback, x1000
    input wire rflm_pkg::rflm_drive_s drive, // Drive status
    output logic [3:0] disp_warn, // Flashing display warnings
    output logic [3:0] warn_level, // Steady warning levels
    output logic [1:0] sig_out, // Signal output terminals
    output logic [1:0] relay_out, // Relay outputs
    output logic closed_loop, // Units: 0 hertz, 1 process unit
    output logic [31:0] process_unit, // Programmed process unit code
    output logic irq // Interrupt, active high
);
    rflm_pkg::rflm_limits_s lim_reg;
    logic [31:0] ctrl_reg;
    logic [31:0] route_reg;
    logic [31:0] unit_reg;
    logic [3:0] stat_reg;
    logic [3:0] mask_reg;
    logic [3:0] warn_reg;
    logic [3:0] warn_next;
    logic [31:0] prdata_reg;
    rflm_pkg::rflm_state_e state_reg;
    logic blink;
    logic ref_below, ref_above, fb_below, fb_above;
    logic armed, ref_en;
    logic wr_en, rd_en, bad_addr;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic signed [31:0] clamp_val(input logic signed [31:0] v,
            input logic signed [31:0] lo, input logic signed [31:0] hi);
        if (v < lo) begin
            clamp_val = lo;
        end else if (v > hi) begin
            clamp_val = hi;
        end else begin
            clamp_val = v;
        end
    endfunction

    function automatic logic is_mapped(input logic [11:0] a);
        is_mapped = (a == rflm_pkg::OFF_CTRL) || (a == rflm_pkg::OFF_REF_LOW) ||
            (a == rflm_pkg::OFF_REF_HIGH) || (a == rflm_pkg::OFF_FB_FLOOR) ||
            (a == rflm_pkg::OFF_FB_CEIL) || (a == rflm_pkg::OFF_LIVE) ||
            (a == rflm_pkg::OFF_IRQ_STAT) || (a == rflm_pkg::OFF_IRQ_MASK) ||
            (a == rflm_pkg::OFF_ROUTE) || (a == rflm_pkg::OFF_UNIT);
    endfunction

    // ****************************************
    // APB slave
    // ****************************************
    assign pready = 1'b1;
    assign bad_addr = !is_mapped(paddr);
    assign pslverr = psel && penable && bad_addr;
    assign wr_en = psel && penable && pwrite && !bad_addr;
    assign rd_en = psel && !penable && !pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lim_reg.ref_low <= rflm_pkg::LIMIT_MIN;
            lim_reg.ref_high <= rflm_pkg::LIMIT_MAX;
            lim_reg.fb_floor <= rflm_pkg::LIMIT_MIN;
            lim_reg.fb_ceil <= rflm_pkg::LIMIT_MAX;
        end else if (wr_en) begin
            unique case (paddr)
                rflm_pkg::OFF_REF_LOW: lim_reg.ref_low <= clamp_val(pwdata, rflm_pkg::LIMIT_MIN, lim_reg.ref_high);
                rflm_pkg::OFF_REF_HIGH: lim_reg.ref_high <= clamp_val(pwdata, lim_reg.ref_low, rflm_pkg::LIMIT_MAX);
                rflm_pkg::OFF_FB_FLOOR: lim_reg.fb_floor <= clamp_val(pwdata, rflm_pkg::LIMIT_MIN, lim_reg.fb_ceil);
                rflm_pkg::OFF_FB_CEIL: lim_reg.fb_ceil <= clamp_val(pwdata, lim_reg.fb_floor, rflm_pkg::LIMIT_MAX);
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= rflm_pkg::CTRL_RST;
            route_reg <= rflm_pkg::ROUTE_RST;
            unit_reg <= rflm_pkg::UNIT_RST;
            mask_reg <= rflm_pkg::MASK_RST;
        end else if (wr_en) begin
            if (paddr == rflm_pkg::OFF_CTRL) begin
                ctrl_reg <= {31'h0000_0000, pwdata[rflm_pkg::CTRL_CLOSED_LOOP]};
            end
            if (paddr == rflm_pkg::OFF_ROUTE) begin
                route_reg <= {16'h0000, pwdata[15:0]};
            end
            if (paddr == rflm_pkg::OFF_UNIT) begin
                unit_reg <= pwdata;
            end
            if (paddr == rflm_pkg::OFF_IRQ_MASK) begin
                mask_reg <= pwdata[3:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (rd_en) begin
            unique case (paddr)
                rflm_pkg::OFF_CTRL: prdata_reg <= ctrl_reg;
                rflm_pkg::OFF_REF_LOW: prdata_reg <= lim_reg.ref_low;
                rflm_pkg::OFF_REF_HIGH: prdata_reg <= lim_reg.ref_high;
                rflm_pkg::OFF_FB_FLOOR: prdata_reg <= lim_reg.fb_floor;
                rflm_pkg::OFF_FB_CEIL: prdata_reg <= lim_reg.fb_ceil;
                rflm_pkg::OFF_LIVE: prdata_reg <= {26'h000_0000, armed, state_reg == rflm_pkg::ST_ARMED, warn_reg};
                rflm_pkg::OFF_IRQ_STAT: prdata_reg <= {28'h000_0000, stat_reg};
                rflm_pkg::OFF_IRQ_MASK: prdata_reg <= {28'h000_0000, mask_reg};
                rflm_pkg::OFF_ROUTE: prdata_reg <= route_reg;
                rflm_pkg::OFF_UNIT: prdata_reg <= unit_reg;
                default: prdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    assign prdata = prdata_reg;

    // ****************************************
    // Suppression state
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= rflm_pkg::ST_SUPPRESS;
        end else begin
            unique case (state_reg)
                rflm_pkg::ST_SUPPRESS: if (drive.running && drive.at_reference) begin
                    state_reg <= rflm_pkg::ST_ARMED;
                end
                rflm_pkg::ST_ARMED: if (!drive.running) begin
                    state_reg <= rflm_pkg::ST_SUPPRESS;
                end
                default: state_reg <= rflm_pkg::ST_SUPPRESS;
            endcase
        end
    end

    // Stop or new ramp drops arming at once
    assign armed = (state_reg == rflm_pkg::ST_ARMED) && drive.running && drive.at_reference;
    assign ref_en = armed && drive.remote_sel;

    // ****************************************
    // Comparisons
    // ****************************************
    rflm_compare u_ref_cmp (
        .value(ref_value),
        .low_lim(lim_reg.ref_low),
        .high_lim(lim_reg.ref_high),
        .enable(ref_en),
        .below(ref_below),
        .above(ref_above)
    );

    rflm_compare u_fb_cmp (
        .value(fb_value),
        .low_lim(lim_reg.fb_floor),
        .high_lim(lim_reg.fb_ceil),
        .enable(armed),
        .below(fb_below),
        .above(fb_above)
    );

    always_comb begin
        warn_next = 4'h0;
        warn_next[rflm_pkg::W_REF_LOW] = ref_below;
        warn_next[rflm_pkg::W_REF_HIGH] = ref_above;
        warn_next[rflm_pkg::W_FEEDBACK_FLOOR_LIMIT] = fb_below;
        warn_next[rflm_pkg::W_FEEDBACK_CEILING_LIMIT] = fb_above;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            warn_reg <= 4'h0;
        end else begin
            warn_reg <= warn_next;
        end
    end

    rflm_flash #(
        .HALF_CYC(FLASH_HALF)
    ) u_flash (
        .pclk(pclk),
        .presetn(presetn),
        .blink(blink)
    );

    assign warn_level = warn_reg;
    assign disp_warn = warn_reg & {4{blink}};

    // ****************************************
    // Output routing: route[3:0] to sig 0, [7:4] sig 1, [11:8] relay 0, [15:12] relay 1
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sig_out <= 2'b00;
            relay_out <= 2'b00;
        end else begin
            sig_out[0] <= |(warn_next & route_reg[3:0]);
            sig_out[1] <= |(warn_next & route_reg[7:4]);
            relay_out[0] <= |(warn_next & route_reg[11:8]);
            relay_out[1] <= |(warn_next & route_reg[15:12]);
        end
    end

    assign closed_loop = ctrl_reg[rflm_pkg::CTRL_CLOSED_LOOP];
    assign process_unit = unit_reg;

    // ****************************************
    // Interrupts
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_reg <= 4'h0;
        end else begin
            if (wr_en && paddr == rflm_pkg::OFF_IRQ_STAT) begin
                stat_reg <= (stat_reg & ~pwdata[3:0]) | (warn_next & ~warn_reg);
            end else begin
                stat_reg <= stat_reg | (warn_next & ~warn_reg);
            end
        end
    end

    assign irq = |(stat_reg & mask_reg);

    // ****************************************
    // Checks
    // ****************************************
    AST_SUPPRESS: assert property (@(posedge pclk) disable iff (!presetn)
        !drive.running |=> warn_reg == 4'h0) else $error("warning while stopped");
    AST_REMOTE: assert property (@(posedge pclk) disable iff (!presetn)
        !drive.remote_sel |=> warn_reg[1:0] == 2'b00) else $error("reference warning without remote");
    AST_REF_LOW: assert property (@(posedge pclk) disable iff (!presetn)
        ref_en && ref_value < lim_reg.ref_low |=> warn_reg[0]) else $error("low reference missed");
    AST_REF_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
        ref_en && ref_value > lim_reg.ref_high |=> warn_reg[1]) else $error("high reference missed");
    AST_FEEDBACK_FLOOR_LIMIT: assert property (@(posedge pclk) disable iff (!presetn)
        armed && fb_value < lim_reg.fb_floor |=> warn_reg[2]) else $error("low feedback missed");
    AST_FEEDBACK_CEILING_LIMIT: assert property (@(posedge pclk) disable iff (!presetn)
        armed && fb_value > lim_reg.fb_ceil |=> warn_reg[3]) else $error("high feedback missed");
    AST_EQUAL: assert property (@(posedge pclk) disable iff (!presetn)
        fb_value == lim_reg.fb_ceil |=> !warn_reg[3]) else $error("equality raised warning");
    AST_ORDER: assert property (@(posedge pclk) disable iff (!presetn)
        lim_reg.fb_ceil >= lim_reg.fb_floor && lim_reg.ref_high >= lim_reg.ref_low) else $error("limits crossed");
    AST_ROUTE: assert property (@(posedge pclk) disable iff (!presetn)
        route_reg[11:8] == 4'h0 |=> !relay_out[0]) else $error("relay driven unrouted");

    // ****************************************
    // Range, strictness, arming, display and routing checks
    // ****************************************
    AST_ARMED_GATE: assert property (@(posedge pclk) disable iff (!presetn)
        !armed |=> warn_reg == 4'h0) else $error("warning while not at reference");
    AST_ARM_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == rflm_pkg::ST_SUPPRESS && !(drive.running && drive.at_reference) |=>
        state_reg == rflm_pkg::ST_SUPPRESS) else $error("armed before reaching reference");
    AST_REF_EQ_LOW: assert property (@(posedge pclk) disable iff (!presetn)
        ref_value == lim_reg.ref_low |=> !warn_reg[0]) else $error("equal low reference raised warning");
    AST_REF_EQ_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
        ref_value == lim_reg.ref_high |=> !warn_reg[1]) else $error("equal high reference raised warning");
    AST_FB_EQ_LOW: assert property (@(posedge pclk) disable iff (!presetn)
        fb_value == lim_reg.fb_floor |=> !warn_reg[2]) else $error("equal low feedback raised warning");
    AST_REF_INSIDE: assert property (@(posedge pclk) disable iff (!presetn)
        ref_value >= lim_reg.ref_low && ref_value <= lim_reg.ref_high |=> warn_reg[1:0] == 2'b00)
        else $error("reference warning inside limits");
    AST_FB_INSIDE: assert property (@(posedge pclk) disable iff (!presetn)
        fb_value >= lim_reg.fb_floor && fb_value <= lim_reg.fb_ceil |=> warn_reg[3:2] == 2'b00)
        else $error("feedback warning inside limits");
    AST_BLINK_GATE: assert property (@(posedge pclk) disable iff (!presetn)
        (disp_warn & ~warn_level) == 4'h0) else $error("display shows inactive warning");
    AST_RELAY_HI: assert property (@(posedge pclk) disable iff (!presetn)
        route_reg[15:12] == 4'h0 |=> !relay_out[1]) else $error("relay one driven unrouted");
    AST_SIG_LO: assert property (@(posedge pclk) disable iff (!presetn)
        (warn_next & route_reg[3:0]) != 4'h0 |=> sig_out[0]) else $error("routed warning missing on output");
    AST_REF_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
        lim_reg.ref_high <= rflm_pkg::LIMIT_MAX && lim_reg.ref_low >= rflm_pkg::LIMIT_MIN)
        else $error("reference limit out of range");
    AST_FB_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
        lim_reg.fb_ceil <= rflm_pkg::LIMIT_MAX && lim_reg.fb_floor >= rflm_pkg::LIMIT_MIN)
        else $error("feedback limit out of range");
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the reference and feedback limit monitor
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Signals and clock
    // ****************************************
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic signed [31:0] ref_value;
    logic signed [31:0] fb_value;
    rflm_pkg::rflm_drive_s drive;
    logic [3:0] disp_warn;
    logic [3:0] warn_level;
    logic [1:0] sig_out;
    logic [1:0] relay_out;
    logic closed_loop;
    logic [31:0] process_unit;
    logic irq;
    int failures = 0;
    int checks = 0;
    int cyc = 0;
    localparam int HALF = 4;
    rflm_top #(.FLASH_HALF(HALF)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ref_value(ref_value), .fb_value(fb_value), .drive(drive), .disp_warn(disp_warn),
        .warn_level(warn_level), .sig_out(sig_out), .relay_out(relay_out), .closed_loop(closed_loop),
        .process_unit(process_unit), .irq(irq));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic stop_test();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures = failures + 1;
            stop_test();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
        output logic err);
        logic rdy;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        rdy = 1'b0;
        while (rdy !== 1'b1) begin
            @(posedge pclk);
            rd = prdata;
            err = pslverr;
            rdy = pready;
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, d, rd, err);
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, 32'h0000_0000, rd, err);
        check(rd, exp);
        check({31'h0, err}, {31'h0, exp == 32'h0000_0000 && a >= 12'h028});
    endtask
    task automatic drv(input logic [31:0] r, input logic [31:0] f, input logic [2:0] d);
        @(posedge pclk);
        ref_value <= r;
        fb_value <= f;
        drive <= d;
        repeat (3) @(posedge pclk);
        @(negedge pclk);
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        logic [31:0] exp [10] = '{32'h0, 32'hC465_3601, 32'h3B9A_C9FF, 32'hC465_3601, 32'h3B9A_C9FF,
            32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
        for (int i = 0; i < 10; i++) begin
            if (i != 5) rd_chk(12'(4 * i), exp[i]);
        end
        check({18'h0_0000, irq, closed_loop, sig_out, relay_out, warn_level, disp_warn}, 32'h0000_0000);
    endtask
    task automatic t_limits();
        wr(rflm_pkg::OFF_REF_LOW, 32'h0000_03E8);
        wr(rflm_pkg::OFF_REF_HIGH, 32'h0000_01F4);
        rd_chk(rflm_pkg::OFF_REF_HIGH, 32'h0000_03E8);
        wr(rflm_pkg::OFF_REF_HIGH, 32'h7FFF_FFFF);
        rd_chk(rflm_pkg::OFF_REF_HIGH, 32'h3B9A_C9FF);
        wr(rflm_pkg::OFF_REF_HIGH, 32'h0000_1388);
        wr(rflm_pkg::OFF_FB_FLOOR, 32'h0000_07D0);
        wr(rflm_pkg::OFF_FB_CEIL, 32'h0000_07CF);
        rd_chk(rflm_pkg::OFF_FB_CEIL, 32'h0000_07D0);
        wr(rflm_pkg::OFF_FB_CEIL, 32'h0000_0BB8);
        rd_chk(rflm_pkg::OFF_FB_CEIL, 32'h0000_0BB8);
    endtask
    task automatic t_compare();
        logic [67:0] tbl [10] = '{{32'h3E8, 32'h9C4, 4'h0}, {32'h3E7, 32'h9C4, 4'h1}, {32'h1389, 32'h9C4, 4'h2},
            {32'h1388, 32'h9C4, 4'h0}, {32'hBB8, 32'h7CF, 4'h4}, {32'hBB8, 32'h7D0, 4'h0},
            {32'hBB8, 32'hBB9, 4'h8}, {32'hBB8, 32'hBB8, 4'h0}, {32'h3E7, 32'hBB9, 4'h9}, {32'hBB8, 32'h9C4, 4'h0}};
        for (int i = 0; i < 10; i++) begin
            drv(tbl[i][67:36], tbl[i][35:4], 3'b111);
            check({28'h0, warn_level}, {28'h0, tbl[i][3:0]});
            rd_chk(rflm_pkg::OFF_LIVE, {26'h0, 2'b11, tbl[i][3:0]});
        end
    endtask
    task automatic t_suppress();
        logic [2:0] dv [6] = '{3'b100, 3'b000, 3'b101, 3'b111, 3'b110, 3'b111};
        logic [3:0] ex [6] = '{4'h0, 4'h0, 4'h0, 4'h9, 4'h8, 4'h9};
        for (int i = 0; i < 6; i++) begin
            drv(32'h0000_03E7, 32'h0000_0BB9, dv[i]);
            check({28'h0, warn_level}, {28'h0, ex[i]});
        end
        drv(32'h0000_0BB8, 32'h0000_09C4, 3'b111);
        check({28'h0, warn_level}, 32'h0000_0000);
    endtask
    task automatic t_route();
        wr(rflm_pkg::OFF_ROUTE, 32'h0000_F681);
        drv(32'h0000_03E7, 32'h0000_0BB9, 3'b111);
        check({28'h0, relay_out, sig_out}, 32'h0000_000B);
        drv(32'h0000_0BB8, 32'h0000_07CF, 3'b111);
        check({28'h0, relay_out, sig_out}, 32'h0000_000C);
    endtask
    task automatic t_irq();
        drv(32'h0000_0BB8, 32'h0000_09C4, 3'b111);
        wr(rflm_pkg::OFF_IRQ_STAT, 32'h0000_000F);
        rd_chk(rflm_pkg::OFF_IRQ_STAT, 32'h0000_0000);
        drv(32'h0000_1389, 32'h0000_09C4, 3'b111);
        rd_chk(rflm_pkg::OFF_IRQ_STAT, 32'h0000_0002);
        check({31'h0, irq}, 32'h0000_0000);
        wr(rflm_pkg::OFF_IRQ_MASK, 32'h0000_0002);
        @(negedge pclk);
        check({31'h0, irq}, 32'h0000_0001);
        wr(rflm_pkg::OFF_IRQ_STAT, 32'h0000_0002);
        @(negedge pclk);
        check({31'h0, irq}, 32'h0000_0000);
        drv(32'h0000_0BB8, 32'h0000_09C4, 3'b111);
        drv(32'h0000_1389, 32'h0000_09C4, 3'b111);
        check({31'h0, irq}, 32'h0000_0001);
        wr(rflm_pkg::OFF_IRQ_MASK, 32'h0000_0000);
        @(negedge pclk);
        check({31'h0, irq}, 32'h0000_0000);
    endtask
    task automatic t_flash();
        int hi = 0;
        int stray = 0;
        drv(32'h0000_03E7, 32'h0000_09C4, 3'b111);
        for (int i = 0; i < 16; i++) begin
            @(negedge pclk);
            hi += disp_warn[0];
            stray += ((disp_warn & ~warn_level) != 4'h0);
        end
        check(32'(hi), 32'h0000_0008);
        check(32'(stray), 32'h0000_0000);
    endtask
    task automatic t_ctrl();
        wr(rflm_pkg::OFF_CTRL, 32'h0000_0001);
        wr(rflm_pkg::OFF_UNIT, 32'h0000_0007);
        @(negedge pclk);
        check({30'h0, closed_loop, process_unit == 32'h0000_0007}, 32'h0000_0003);
        rd_chk(rflm_pkg::OFF_UNIT, 32'h0000_0007);
        rd_chk(12'h040, 32'h0000_0000);
        wr(rflm_pkg::OFF_CTRL, 32'h0000_0000);
        @(negedge pclk);
        check({31'h0, closed_loop}, 32'h0000_0000);
        wr(rflm_pkg::OFF_CTRL, 32'h0000_0001);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(rflm_pkg::OFF_CTRL, 32'h0000_0000);
        rd_chk(rflm_pkg::OFF_REF_HIGH, 32'h3B9A_C9FF);
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        ref_value = 32'sh0000_0000;
        fb_value = 32'sh0000_0000;
        drive = 3'b000;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_limits();
        t_compare();
        t_suppress();
        t_route();
        t_irq();
        t_flash();
        t_ctrl();
        stop_test();
    end
endmodule
